// ### amc_pkg.sv
// Purpose: Shared constants for the converter operating-mode sequencer.
// Assumes: One 125 MHz clock; APB slave with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package amc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_IOPORT = 8'h08;
  localparam logic [7:0] OFF_DATA   = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ    = 8'h14;
  localparam logic [7:0] OFF_MASK   = 8'h18;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int          MODE_MSB      = 15;
  localparam int          MODE_LSB      = 13;
  localparam int          SWITCH_BIT    = 12;
  localparam logic [15:0] MODE_RESET    = 16'h000a;
  localparam logic [2:0]  MD_CONT       = 3'h0;
  localparam logic [2:0]  MD_SINGLE     = 3'h1;
  localparam logic [2:0]  MD_IDLE       = 3'h2;
  localparam logic [2:0]  MD_PDOWN      = 3'h3;
  localparam int          SETTLE_PERIODS = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int UPDATE_PERIOD_NS = 2000;
  localparam int UPDATE_CYCLES = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    AMC_ST_PDOWN  = 5'h01,
    AMC_ST_IDLE   = 5'h02,
    AMC_ST_SETTLE = 5'h04,
    AMC_ST_RUN    = 5'h08,
    AMC_ST_CAL    = 5'h10
  } amc_state_e;

endpackage

// ### amc_period_timer.sv
// Purpose: Update-rate period timer, pulses once per period while running.
// Assumes: Synchronous restart input.
// Notes:   Restart reloads the count so a new period starts cleanly.
`timescale 1ns/1ps
module amc_period_timer #(
  parameter int PERIOD = amc_pkg::UPDATE_CYCLES
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  // Control
  input  wire logic run,
  input  wire logic restart,
  // Tick
  output logic      tick
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick     = 1'b0;
    if (restart || !run) begin
      cnt_next = 32'h0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_next = 32'h0;
      tick     = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ### amc_mode_ctrl.sv
// Purpose: Operating-mode sequencer of a sigma-delta converter with APB registers.
// Assumes: Modulator supplies a result word, sampled on the update tick that completes a conversion; calibration is elsewhere.
// Notes:   Ready is active low, set (high) while no unread result is held.
// Summary of operation
// - Mode is the three top bits of the sixteen-bit mode register.
// - Code zero selects continuous conversion, the mode after reset.
// - Continuous mode converts repeatedly, storing each result in the data register.
// - Ready goes low each time a new result is available.
// - Continuous read shifts each result out on serial clock pulses.
// - First result after reset or config write comes after two update periods.
// - Later results follow one update period apart.
// - Code one does one conversion, ready two periods after selection.
// - Single mode stores result, lowers ready, then powers down itself.
// - Result and low ready are held until read or next conversion.
// - Code two idles: filter and modulator reset, modulator clock runs.
// - Code three powers down everything, switch and burnout currents included.
// - Power-down opens the low-side switch regardless of its control bit.
`timescale 1ns/1ps
module amc_mode_ctrl #(
  parameter int DATA_W = 24,
  parameter int UPDATE_CYC = amc_pkg::UPDATE_CYCLES
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Modulator result
  input  wire logic [DATA_W-1:0] RESULT_DATA,
  // Serial result output
  input  wire logic              CONT_READ,
  input  wire logic              SCLK_PULSE,
  input  wire logic              DATA_READ,
  output logic                   SER_DOUT,
  // Analog control
  output logic                   RDY_N,
  output logic                   MOD_POWER,
  output logic                   FILTER_RESET,
  output logic                   LOW_SIDE_SWITCH,
  output logic                   BURNOUT_EN,
  output logic                   CAL_START,
  output logic      [2:0]        CAL_MODE,
  input  wire logic              CAL_DONE,
  // Interrupt
  output logic                   IRQ
);

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0]       mode_reg,  mode_next;
  logic [15:0]       cfg_reg,   cfg_next;
  logic [15:0]       io_reg,    io_next;
  logic [DATA_W-1:0] data_reg,  data_next;
  logic              rdy_n_reg, rdy_n_next;
  logic [1:0]        irq_reg,   irq_next;
  logic [1:0]        mask_reg,  mask_next;
  logic [DATA_W-1:0] shift_reg, shift_next;
  logic [7:0]        bits_reg,  bits_next;
  logic              dout_reg,  dout_next;
  logic              cal_reg,   cal_next;
  logic [1:0]        per_reg,   per_next;
  amc_pkg::amc_state_e st_reg, st_next;

  logic wr_en, rd_en, cfg_write, tick, timer_run, done_ev;
  logic [2:0] mode_sel;
  logic [31:0]       since_reg, since_next;
  logic [31:0]       gap_reg,   gap_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr_en     = PSEL && PENABLE && PWRITE;
  assign rd_en     = PSEL && PENABLE && !PWRITE;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !(hit(PADDR, amc_pkg::OFF_MODE) || hit(PADDR, amc_pkg::OFF_CONFIG) ||
                     hit(PADDR, amc_pkg::OFF_IOPORT) || hit(PADDR, amc_pkg::OFF_DATA) ||
                     hit(PADDR, amc_pkg::OFF_STATUS) || hit(PADDR, amc_pkg::OFF_IRQ) ||
                     hit(PADDR, amc_pkg::OFF_MASK));
  assign cfg_write = wr_en && (hit(PADDR, amc_pkg::OFF_MODE) || hit(PADDR, amc_pkg::OFF_CONFIG) ||
                     hit(PADDR, amc_pkg::OFF_IOPORT));
  assign mode_sel  = mode_reg[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB];
  assign timer_run = (st_reg == amc_pkg::AMC_ST_SETTLE) || (st_reg == amc_pkg::AMC_ST_RUN);

  amc_period_timer #(
    .PERIOD (UPDATE_CYC)
  ) u_timer (
    .CLOCK   (CLOCK),
    .ARST_N  (ARST_N),
    .run     (timer_run),
    .restart (cfg_write),
    .tick    (tick)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_next  = st_reg;
    per_next = per_reg;
    done_ev  = 1'b0;
    cal_next = 1'b0;
    if (cfg_write) begin
      per_next = 2'h0;
      st_next  = amc_pkg::AMC_ST_SETTLE;
    end else begin
      case (st_reg)
        amc_pkg::AMC_ST_SETTLE: begin
          if (tick) begin
            if (per_reg == 2'(amc_pkg::SETTLE_PERIODS - 1)) begin
              done_ev = 1'b1;
              st_next = (mode_sel == amc_pkg::MD_SINGLE) ? amc_pkg::AMC_ST_PDOWN : amc_pkg::AMC_ST_RUN;
            end else begin
              per_next = per_reg + 2'h1;
            end
          end
        end
        amc_pkg::AMC_ST_RUN:   done_ev = tick;
        amc_pkg::AMC_ST_CAL:   if (CAL_DONE) st_next = amc_pkg::AMC_ST_IDLE;
        amc_pkg::AMC_ST_IDLE:  st_next = amc_pkg::AMC_ST_IDLE;
        amc_pkg::AMC_ST_PDOWN: st_next = amc_pkg::AMC_ST_PDOWN;
        default:               st_next = amc_pkg::AMC_ST_PDOWN;
      endcase
    end
    // Settling resolves the selected mode once the new field is stored.
    if (st_reg == amc_pkg::AMC_ST_SETTLE && !cfg_write) begin
      if (mode_sel == amc_pkg::MD_IDLE) st_next = amc_pkg::AMC_ST_IDLE;
      if (mode_sel == amc_pkg::MD_PDOWN) st_next = amc_pkg::AMC_ST_PDOWN;
      if (mode_sel[2]) begin
        st_next  = amc_pkg::AMC_ST_CAL;
        cal_next = 1'b1;
      end
    end
  end

  // ****************************************
  // Registers, ready flag and serial output
  // ****************************************
  always_comb begin
    mode_next  = mode_reg;
    cfg_next   = cfg_reg;
    io_next    = io_reg;
    mask_next  = mask_reg;
    data_next  = data_reg;
    rdy_n_next = rdy_n_reg;
    shift_next = shift_reg;
    bits_next  = bits_reg;
    dout_next  = dout_reg;
    irq_next   = irq_reg;
    if (wr_en && hit(PADDR, amc_pkg::OFF_MODE))   mode_next = PWDATA[15:0];
    if (wr_en && hit(PADDR, amc_pkg::OFF_CONFIG)) cfg_next  = PWDATA[15:0];
    if (wr_en && hit(PADDR, amc_pkg::OFF_IOPORT)) io_next   = PWDATA[15:0];
    if (wr_en && hit(PADDR, amc_pkg::OFF_MASK))   mask_next = PWDATA[1:0];
    if (wr_en && hit(PADDR, amc_pkg::OFF_IRQ))    irq_next  = irq_reg & ~PWDATA[1:0];
    if (DATA_READ || (rd_en && hit(PADDR, amc_pkg::OFF_DATA))) rdy_n_next = 1'b1;
    // mode, config and I/O port writes set ready high
    if (cfg_write) rdy_n_next = 1'b1;
    if (CONT_READ && SCLK_PULSE && bits_reg != 8'h0) begin
      dout_next  = shift_reg[DATA_W-1];
      shift_next = {shift_reg[DATA_W-2:0], 1'b0};
      bits_next  = bits_reg - 8'h1;
      if (bits_reg == 8'h1) rdy_n_next = 1'b1;
    end
    if (done_ev) begin
      data_next  = RESULT_DATA;
      rdy_n_next = 1'b0;
      shift_next = RESULT_DATA;
      bits_next  = 8'(DATA_W);
      irq_next[0] = 1'b1;
    end
    if (CAL_DONE) irq_next[1] = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_reg  <= amc_pkg::MODE_RESET;
      cfg_reg   <= 16'h0;
      io_reg    <= 16'h0;
      mask_reg  <= 2'h0;
      data_reg  <= '0;
      rdy_n_reg <= 1'b1;
      shift_reg <= '0;
      bits_reg  <= 8'h0;
      dout_reg  <= 1'b0;
      irq_reg   <= 2'h0;
      cal_reg   <= 1'b0;
      per_reg   <= 2'h0;
      st_reg    <= amc_pkg::AMC_ST_SETTLE;
    end else begin
      mode_reg  <= mode_next;
      cfg_reg   <= cfg_next;
      io_reg    <= io_next;
      mask_reg  <= mask_next;
      data_reg  <= data_next;
      rdy_n_reg <= rdy_n_next;
      shift_reg <= shift_next;
      bits_reg  <= bits_next;
      dout_reg  <= dout_next;
      irq_reg   <= irq_next;
      cal_reg   <= cal_next;
      per_reg   <= per_next;
      st_reg    <= st_next;
    end
  end

  always_comb begin
    PRDATA = 32'h0;
    if (rd_en) begin
      case (PADDR)
        amc_pkg::OFF_MODE:   PRDATA = {16'h0, mode_reg};
        amc_pkg::OFF_CONFIG: PRDATA = {16'h0, cfg_reg};
        amc_pkg::OFF_IOPORT: PRDATA = {16'h0, io_reg};
        amc_pkg::OFF_DATA:   PRDATA = 32'(data_reg);
        amc_pkg::OFF_STATUS: PRDATA = {24'h0, rdy_n_reg, 2'h0, st_reg};
        amc_pkg::OFF_IRQ:    PRDATA = {30'h0, irq_reg};
        amc_pkg::OFF_MASK:   PRDATA = {30'h0, mask_reg};
        default:             PRDATA = 32'h0;
      endcase
    end
  end

  // ****************************************
  // Analog controls
  // ****************************************
  assign RDY_N           = rdy_n_reg;
  assign SER_DOUT        = dout_reg;
  assign MOD_POWER       = st_reg != amc_pkg::AMC_ST_PDOWN;
  assign FILTER_RESET    = (st_reg == amc_pkg::AMC_ST_IDLE) || (st_reg == amc_pkg::AMC_ST_PDOWN);
  assign LOW_SIDE_SWITCH = mode_reg[amc_pkg::SWITCH_BIT] && (st_reg != amc_pkg::AMC_ST_PDOWN);
  assign BURNOUT_EN      = st_reg != amc_pkg::AMC_ST_PDOWN;
  assign CAL_START       = cal_reg;
  assign CAL_MODE        = mode_sel;
  assign IRQ             = |(irq_reg & mask_reg);

  // ****************************************
  // Checks
  // ****************************************
  // Cycle counters for the timing checks; they saturate so a long idle spell cannot wrap them.
  always_comb begin
    since_next = (since_reg == 32'hffffffff) ? since_reg : since_reg + 32'h1;
    gap_next   = (gap_reg == 32'hffffffff) ? gap_reg : gap_reg + 32'h1;
    if (cfg_write) since_next = 32'h0;
    if (done_ev) gap_next = 32'h0;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      since_reg <= 32'h0;
      gap_reg   <= 32'h0;
    end else begin
      since_reg <= since_next;
      gap_reg   <= gap_next;
    end
  end

  sequence s_settle_done;
    (st_reg == amc_pkg::AMC_ST_SETTLE) && done_ev;
  endsequence

  sequence s_run_done;
    (st_reg == amc_pkg::AMC_ST_RUN) && done_ev;
  endsequence

  AST_SETTLE_TIME: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_settle_done |-> since_reg == 32'(amc_pkg::SETTLE_PERIODS * UPDATE_CYC - 1)) else $error("settle time wrong");
  AST_RUN_PERIOD: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_run_done |-> gap_reg == 32'(UPDATE_CYC - 1)) else $error("result spacing wrong");
  AST_READ_RELEASES: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    rd_en && hit(PADDR, amc_pkg::OFF_DATA) && !done_ev |=> RDY_N) else $error("read did not release ready");

  AST_PDOWN_SWITCH: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    st_reg == amc_pkg::AMC_ST_PDOWN |-> !LOW_SIDE_SWITCH) else $error("switch closed in power-down");
  AST_PDOWN_BURNOUT: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    st_reg == amc_pkg::AMC_ST_PDOWN |-> !BURNOUT_EN && !MOD_POWER) else $error("power-down incomplete");
  AST_READY_ON_DONE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    done_ev |=> !RDY_N && data_reg == $past(RESULT_DATA)) else $error("result not flagged");
  AST_CFG_SETS_READY: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cfg_write |=> RDY_N && st_reg == amc_pkg::AMC_ST_SETTLE) else $error("ready not set on write");
  AST_SINGLE_PDOWN: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_settle_done ##0 (mode_sel == amc_pkg::MD_SINGLE) |=> st_reg == amc_pkg::AMC_ST_PDOWN)
    else $error("single mode did not power down");
  AST_CONT_RUN: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_settle_done ##0 (mode_sel == amc_pkg::MD_CONT) |=> st_reg == amc_pkg::AMC_ST_RUN)
    else $error("continuous mode did not run");
  AST_IDLE_RESET: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    st_reg == amc_pkg::AMC_ST_IDLE |-> FILTER_RESET && MOD_POWER) else $error("idle filter not reset");
  AST_HOLD_READY: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    st_reg == amc_pkg::AMC_ST_PDOWN && !RDY_N && !DATA_READ && !rd_en && !cfg_write && !SCLK_PULSE |=> !RDY_N)
    else $error("ready lost while held");
  AST_CAL_HANDOFF: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    cal_next |-> st_next == amc_pkg::AMC_ST_CAL && mode_sel[2]) else $error("calibration not handed over");
  AST_FIELD_DECODE: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    wr_en && hit(PADDR, amc_pkg::OFF_MODE) |=> CAL_MODE == $past(PWDATA[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB]))
    else $error("mode field misdecoded");

endmodule

// ### amc_host_model.sv
// Purpose: Host model that fetches results over the serial result port.
// Assumes: The bench enables continuous read or asks for a command read.
// Notes:   A bit is captured one cycle after its pulse, once the registered output has moved.
`timescale 1ns/1ps
module amc_host_model #(
  parameter int DATA_W = 24
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Device side
  input  wire logic              rdy_n,
  input  wire logic              ser_dout,
  input  wire logic              cont_read,
  input  wire logic              cmd_read,
  output logic                   sclk_pulse,
  output logic                   data_read,
  // Captured word
  output logic      [DATA_W-1:0] word,
  output logic                   word_done
);
  int   bit_cnt;
  logic cap_pulse;

  // ****************************************
  // Serial fetch
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_pulse <= 1'b0;
      data_read  <= 1'b0;
      bit_cnt    <= 0;
      word       <= '0;
      word_done  <= 1'b0;
      cap_pulse  <= 1'b0;
    end else begin
      data_read <= cmd_read;
      cap_pulse <= sclk_pulse;
      if (cap_pulse) begin
        word <= {word[DATA_W-2:0], ser_dout};
      end
      if (sclk_pulse) begin
        sclk_pulse <= 1'b0;
      end else if (!cont_read) begin
        bit_cnt   <= 0;
        word_done <= 1'b0;
      end else if (bit_cnt < DATA_W && (!rdy_n || bit_cnt > 0)) begin
        sclk_pulse <= 1'b1;
        bit_cnt    <= bit_cnt + 1;
      end else if (bit_cnt == DATA_W) begin
        word_done <= 1'b1;
      end
    end
  end
endmodule

// ### adc_operating_mode_control_tb_top.sv
// Purpose: Self-checking bench for the operating-mode sequencer.
// Assumes: APB slave; an update period of 64 cycles so a whole serial word fits in one.
// Notes:   Settling counts are checked with one cycle of slack below and two above.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module adc_operating_mode_control_tb_top;
  localparam int U = 64;
  localparam int W = 24;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, seed;
  logic [W-1:0] result, word;
  logic        cont_read, cmd_read, sclk_pulse, data_read, ser_dout, rdy_n, mod_power;
  logic        filter_reset, low_sw, burnout, cal_start, cal_done, irq, word_done, seen;
  logic [2:0]  cal_mode;
  int          miscompares, compares, n;
  time         t0;

  amc_mode_ctrl #(.DATA_W(W), .UPDATE_CYC(U)) i_dut (.CLOCK(clk), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RESULT_DATA(result),
    .CONT_READ(cont_read), .SCLK_PULSE(sclk_pulse), .DATA_READ(data_read), .SER_DOUT(ser_dout),
    .RDY_N(rdy_n), .MOD_POWER(mod_power), .FILTER_RESET(filter_reset), .LOW_SIDE_SWITCH(low_sw),
    .BURNOUT_EN(burnout), .CAL_START(cal_start), .CAL_MODE(cal_mode), .CAL_DONE(cal_done), .IRQ(irq));
  amc_host_model #(.DATA_W(W)) i_host (.clk(clk), .arst_n(arst_n), .rdy_n(rdy_n),
    .ser_dout(ser_dout), .cont_read(cont_read), .cmd_read(cmd_read), .sclk_pulse(sclk_pulse),
    .data_read(data_read), .word(word), .word_done(word_done));

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rdy();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rdy_n !== 1'b0 && n < 1000);
    if (rdy_n !== 1'b0) miscompares++;
  endtask
  task automatic new_result();
    seed = xs(seed);
    result <= seed[W-1:0];
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, cont_read, cmd_read, cal_done} = '0;
    miscompares = 0;
    compares = 0;
    seed = 32'h5f36;
    result = '0;
    new_result();
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_rdy();
    `CHK("first", 1'b1, n >= 2*U-1 && n <= 2*U+2)
    t0 = $time;
    apb(1'b0, amc_pkg::OFF_DATA, 32'h0);
    `CHK("data", result, rdata[W-1:0])
    wait_rdy();
    `CHK("period", 1'b1, ($time-t0)/8 >= U-1 && ($time-t0)/8 <= U+1)
    apb(1'b0, amc_pkg::OFF_MODE, 32'h0);
    `CHK("mode", 16'h000a, rdata[15:0])
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
    $display("test reset done");
    apb(1'b1, amc_pkg::OFF_MODE, 32'h1000);
    apb(1'b1, amc_pkg::OFF_IRQ, 32'h1);
    apb(1'b1, amc_pkg::OFF_MASK, 32'h1);
    @(negedge clk);
    `CHK("irqpre", 1'b0, irq)
    wait_rdy();
    `CHK("irq", 1'b1, irq)
    `CHK("switch", 1'b1, low_sw)
    apb(1'b1, amc_pkg::OFF_MODE, 32'h7000);
    repeat (3) @(negedge clk);
    `CHK("pd", 4'h8, {rdy_n, mod_power, low_sw, burnout})
    apb(1'b1, amc_pkg::OFF_IRQ, 32'h1);
    @(negedge clk);
    `CHK("irqclr", 1'b0, irq)
    apb(1'b1, amc_pkg::OFF_MASK, 32'h0);
    $display("test powerdown done");
    new_result();
    apb(1'b1, amc_pkg::OFF_MODE, 32'h2000);
    wait_rdy();
    `CHK("single", 1'b1, n >= 2*U-1 && n <= 2*U+2)
    repeat (3*U) @(negedge clk);
    `CHK("hold", 2'b00, {rdy_n, mod_power})
    apb(1'b0, amc_pkg::OFF_DATA, 32'h0);
    `CHK("sdata", result, rdata[W-1:0])
    @(negedge clk);
    `CHK("sread", 1'b1, rdy_n)
    $display("test single done");
    apb(1'b1, amc_pkg::OFF_MODE, 32'h4000);
    repeat (3*U) @(negedge clk);
    `CHK("idle", 3'h7, {filter_reset, mod_power, rdy_n})
    $display("test idle done");
    for (int c = 4; c < 8; c++) begin
      seen = 1'b0;
      apb(1'b1, amc_pkg::OFF_MODE, {16'h0, c[2:0], 13'h0});
      repeat (4) begin
        @(negedge clk);
        seen |= cal_start;
      end
      `CHK("calstart", 1'b1, seen)
      `CHK("calmode", c[2:0], cal_mode)
      @(posedge clk);
      cal_done <= 1'b1;
      @(posedge clk);
      cal_done <= 1'b0;
      apb(1'b0, amc_pkg::OFF_STATUS, 32'h0);
      `CHK("calidle", 8'h82, rdata[7:0])
    end
    apb(1'b0, amc_pkg::OFF_IRQ, 32'h0);
    `CHK("calirq", 1'b1, rdata[1])
    $display("test cal done");
    new_result();
    cont_read <= 1'b1;
    apb(1'b1, amc_pkg::OFF_MODE, 32'h0);
    n = 0;
    while (word_done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    `CHK("serialdone", 1'b1, word_done)
    `CHK("serial", result, word)
    @(posedge clk);
    cont_read <= 1'b0;
    wait_rdy();
    @(posedge clk);
    cmd_read <= 1'b1;
    @(posedge clk);
    cmd_read <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("cmdread", 1'b1, rdy_n)
    $display("test serial done");
    print_verdict();
  end
endmodule
